// File: rtl/wdt_top.sv
// windowed watchdog timer with apb register access
`timescale 1ns/1ps
// What this block does
// - clocked by rc oscillator, enabling forces it on
// - prescaler divides by 32 or 128
// - postscaler selects 1:1 to 1:32768
// - reset and clock switch clear counts
// - power save entry clears counts
// - power save exit clears counts
// - clear instruction resets counts periodically
// - runs in sleep/idle, time-out wakes
// - hard enable runs it until reset or a config word write clears the bit
// - otherwise soft enable bit runs it
// - soft enable clears on reset
// - timeout flag set, cleared only by software or reset
// - window mode limits when clear allowed
module wdt_top #(
   parameter int CLK_HZ = wdt_pkg::PCLK_HZ,
   parameter int OSC_HZ = wdt_pkg::OSC_NOM_HZ
)
(
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // to the core
   output logic wake_req,
   output logic device_reset_req,
   output logic osc_on,
   output logic irq
);
   // ****************************************************************
   // declarations
   // ****************************************************************
   logic [9:0] cfg_r;                 // watchdog_config_word
   logic sw_en_r;                     // soft_watchdog_enable
   logic tmo_flag_r; // watchdog_timeout_flag
   logic sleep_r;                     // sleep status flag
   logic idle_r;                      // idle status flag
   logic [2:0] stat_r;                // sticky interrupt status
   logic [2:0] mask_r;                // interrupt mask
   logic [6:0] pre_r;                 // prescaler count
   logic [15:0] post_r;               // postscaler count
   wdt_pkg::wdt_pwr_type pwr_r;       // core power state
   logic enabled;                     // watchdog running
   logic tick; // oscillator period tick
   logic wr;                          // write access phase
   logic rd;                          // read access phase
   logic cmd_wr;                      // write to command register
   logic clr_cmd;                     // clear_watchdog_instr
   logic save_cmd;                    // power_save_instr
   logic wake_cmd;                    // external wake
   logic sw_cmd;                      // clock switch completed
   logic pre_done;                    // prescaler wraps
   logic timeout;                     // postscaler reached its ratio
   logic win_fault;                   // clear before window opens
   logic clear_counts;                // clear all divider stages
   logic [15:0] post_last;            // terminal postscaler count
   logic [15:0] win_open;             // count at which window opens
   logic [6:0] pre_last;              // terminal prescaler count
   logic [1:0] win_sel;               // window_select field

   // ****************************************************************
   // enable and oscillator
   // ****************************************************************
   assign enabled = cfg_r[wdt_pkg::CFG_HARDEN_BIT] | sw_en_r;

   // oscillator is forced on with the watchdog
   wdt_osc_tick #(
      .CLK_HZ(CLK_HZ),
      .OSC_HZ(OSC_HZ)
   ) u_osc (
      .pclk(pclk),
      .presetn(presetn),
      .run(enabled),
      .tick(tick)
   );

   // ****************************************************************
   // apb decode and command strobes
   // ****************************************************************
   // only the edge that completes the access acts, so a strobe never repeats
   assign wr = psel & penable & pready & pwrite;
   assign rd = psel & penable & pready & ~pwrite;
   assign cmd_wr = wr & (paddr == wdt_pkg::CMD_OFS);
   assign clr_cmd = cmd_wr & pwdata[wdt_pkg::CMD_CLEAR_BIT] & (pwr_r == wdt_pkg::PWR_RUN);
   assign save_cmd = cmd_wr & (pwdata[wdt_pkg::CMD_SLEEP_BIT] | pwdata[wdt_pkg::CMD_IDLE_BIT])
                     & (pwr_r == wdt_pkg::PWR_RUN);
   assign wake_cmd = cmd_wr & pwdata[wdt_pkg::CMD_WAKE_BIT] & (pwr_r != wdt_pkg::PWR_RUN);
   assign sw_cmd = cmd_wr & pwdata[wdt_pkg::CMD_SWITCH_BIT];

   // ****************************************************************
   // divider terminal values
   // ****************************************************************
   assign pre_last = cfg_r[wdt_pkg::CFG_PRE_BIT] ? 7'(wdt_pkg::PRE_LONG - 1)
                                                  : 7'(wdt_pkg::PRE_SHORT - 1);
   assign post_last = 16'((32'h1 << cfg_r[wdt_pkg::CFG_POST_LSB +: 4]) - 32'h1);
   assign win_sel = cfg_r[wdt_pkg::CFG_WIN_LSB +: 2];

   // window opens at 25, 37.5, 50 or 75 percent of the period
   always_comb
   begin
      case (win_sel)
         2'b00: win_open = 16'(post_last - (post_last >> 2));
         2'b01: win_open = post_last >> 1;
         2'b10: win_open = 16'(post_last - (post_last >> 1) - (post_last >> 3));
         2'b11: win_open = post_last >> 2;
         default: win_open = post_last;
      endcase
   end

   assign pre_done = tick & (pre_r == pre_last);
   assign timeout = enabled & pre_done & (post_r == post_last);
   assign win_fault = clr_cmd & enabled & ~cfg_r[wdt_pkg::CFG_WINOFF_BIT]
                      & (post_r < win_open);
   assign clear_counts = ~enabled | clr_cmd | save_cmd | wake_cmd | sw_cmd
                         | (timeout & (pwr_r != wdt_pkg::PWR_RUN));

   // ****************************************************************
   // prescaler and postscaler
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_r <= 7'h00;
         post_r <= 16'h0000;
      end
      else if (clear_counts)
      begin
         pre_r <= 7'h00;
         post_r <= 16'h0000;
      end
      else if (tick)
      begin
         // counting continues in any power state
         if (pre_done)
         begin
            pre_r <= 7'h00;
            post_r <= (post_r == post_last) ? 16'h0000 : post_r + 16'h0001;
         end
         else
         begin
            pre_r <= pre_r + 7'h01;
         end
      end
   end

   // ****************************************************************
   // power state of the core
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pwr_r <= wdt_pkg::PWR_RUN;
      end
      else
      begin
         case (pwr_r)
            wdt_pkg::PWR_RUN:
               if (save_cmd)
                  pwr_r <= pwdata[wdt_pkg::CMD_SLEEP_BIT] ? wdt_pkg::PWR_SLEEP : wdt_pkg::PWR_IDLE;
            wdt_pkg::PWR_SLEEP, wdt_pkg::PWR_IDLE:
               // a time-out or an outside wake returns to run
               if (timeout | wake_cmd)
                  pwr_r <= wdt_pkg::PWR_RUN;
            default:
               pwr_r <= wdt_pkg::PWR_RUN;
         endcase
      end
   end

   // ****************************************************************
   // configuration word
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cfg_r <= wdt_pkg::CFG_RESET;
      else if (wr & (paddr == wdt_pkg::CONFIG_OFS))
         cfg_r <= pwdata[9:0];
   end

   // ****************************************************************
   // reset control register
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sw_en_r <= 1'b0;
         tmo_flag_r <= 1'b0;
         sleep_r <= 1'b0;
         idle_r <= 1'b0;
      end
      else
      begin
         if (wr & (paddr == wdt_pkg::RESET_CTRL_OFS))
         begin
            sw_en_r <= pwdata[wdt_pkg::RC_SWEN_BIT];
            tmo_flag_r <= pwdata[wdt_pkg::RC_TMO_BIT];
            sleep_r <= pwdata[wdt_pkg::RC_SLEEP_BIT];
            idle_r <= pwdata[wdt_pkg::RC_IDLE_BIT];
         end
         // hardware sets win over software clears
         if (timeout | win_fault)
            tmo_flag_r <= 1'b1;
         if (save_cmd & pwdata[wdt_pkg::CMD_SLEEP_BIT])
            sleep_r <= 1'b1;
         else if (save_cmd)
            idle_r <= 1'b1;
      end
   end

   // ****************************************************************
   // interrupt status and mask
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stat_r <= 3'h0;
         mask_r <= 3'h0;
      end
      else
      begin
         if (wr & (paddr == wdt_pkg::MASK_OFS))
            mask_r <= pwdata[2:0];
         // a read clears only the bits it returned, so an event after the snapshot survives
         stat_r <= (stat_r & ~((rd & (paddr == wdt_pkg::STATUS_OFS)) ? prdata[2:0] : 3'h0))
                   | {timeout & (pwr_r != wdt_pkg::PWR_RUN), win_fault, timeout};
      end
   end

   // ****************************************************************
   // outputs to the core
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wake_req <= 1'b0;
         device_reset_req <= 1'b0;
         osc_on <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         wake_req <= timeout & (pwr_r != wdt_pkg::PWR_RUN);
         device_reset_req <= (timeout & (pwr_r == wdt_pkg::PWR_RUN)) | win_fault;
         osc_on <= enabled;
         irq <= |(stat_r & mask_r);
      end
   end

   // ****************************************************************
   // apb read data, zero wait states
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (psel & ~penable)
         begin
            case (paddr)
               wdt_pkg::CONFIG_OFS: prdata <= {22'h000000, cfg_r};
               wdt_pkg::RESET_CTRL_OFS: prdata <= {26'h0000000, sw_en_r, tmo_flag_r, sleep_r, idle_r, 2'b00};
               wdt_pkg::STATUS_OFS: prdata <= {29'h00000000, stat_r};
               wdt_pkg::MASK_OFS: prdata <= {29'h00000000, mask_r};
               wdt_pkg::CMD_OFS: prdata <= 32'h00000000;
               wdt_pkg::COUNT_OFS: prdata <= {16'h0000, post_r};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule

// File: pkg/wdt_pkg.sv
// package: register map, field positions, reset values and divider settings of the windowed watchdog
package wdt_pkg;

   // ****************************************************************
   // register offsets (byte addresses on the apb)
   // ****************************************************************
   localparam logic [7:0] CONFIG_OFS = 8'h00;   // watchdog_config_word
   localparam logic [7:0] RESET_CTRL_OFS = 8'h04; // reset_control_reg
   localparam logic [7:0] STATUS_OFS = 8'h08;   // interrupt status, read clears
   localparam logic [7:0] MASK_OFS = 8'h0C;     // interrupt mask
   localparam logic [7:0] CMD_OFS = 8'h10;      // instruction strobes from the core
   localparam logic [7:0] COUNT_OFS = 8'h14;    // live postscaler count, read only

   // ****************************************************************
   // watchdog_config_word fields
   // ****************************************************************
   localparam int CFG_POST_LSB = 0;     // postscale_select <3:0>
   localparam int CFG_PRE_BIT = 4;      // prescale_select
   localparam int CFG_WIN_LSB = 7;      // window_select <8:7>
   localparam int CFG_WINOFF_BIT = 6;   // window_disable
   localparam int CFG_HARDEN_BIT = 9;   // hard_watchdog_enable
   localparam logic [9:0] CFG_RESET = 10'h04F; // window off, /32, 1:32768

   // ****************************************************************
   // reset_control_reg fields
   // ****************************************************************
   localparam int RC_IDLE_BIT = 2;
   localparam int RC_SLEEP_BIT = 3;
   localparam int RC_TMO_BIT = 4;       // watchdog_timeout_flag
   localparam int RC_SWEN_BIT = 5;      // soft_watchdog_enable

   // ****************************************************************
   // command register strobes
   // ****************************************************************
   localparam int CMD_CLEAR_BIT = 0;    // clear_watchdog_instr
   localparam int CMD_SLEEP_BIT = 1;    // power_save_instr, sleep
   localparam int CMD_IDLE_BIT = 2;     // power_save_instr, idle
   localparam int CMD_WAKE_BIT = 3;     // exit of power save by other source
   localparam int CMD_SWITCH_BIT = 4;   // clock switch completed

   // ****************************************************************
   // interrupt status bits
   // ****************************************************************
   localparam int IRQ_TIMEOUT_BIT = 0;
   localparam int IRQ_WINFAULT_BIT = 1;
   localparam int IRQ_WAKE_BIT = 2;

   // ****************************************************************
   // oscillator and divider figures
   // ****************************************************************
   localparam int OSC_NOM_HZ = 32000;   // nominal low_power_rc_osc rate
   localparam int PCLK_HZ = 40000000;   // bus clock rate
   localparam int PRE_SHORT = 32;       // 5-bit prescaler
   localparam int PRE_LONG = 128;       // 7-bit prescaler
   localparam int POST_BITS = 16;       // enough for 1:32768

   // power state of the core
   typedef enum logic [1:0] {
      PWR_RUN = 2'b00,
      PWR_SLEEP = 2'b01,
      PWR_IDLE = 2'b10
   } wdt_pwr_type;

endpackage

// File: rtl/wdt_osc_tick.sv
// low power rc oscillator model: a tick every oscillator period, derived from pclk
`timescale 1ns/1ps
module wdt_osc_tick #(
   parameter int CLK_HZ = 40000000,
   parameter int OSC_HZ = 32000
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic run,
   // output
   output logic tick
);
   // ****************************************************************
   // divider
   // ****************************************************************
   localparam int DIV = (CLK_HZ / OSC_HZ > 1) ? CLK_HZ / OSC_HZ : 1;
   localparam logic [15:0] LAST = 16'(DIV - 1);

   logic [15:0] cnt_r; // phase of the oscillator

   // oscillator only runs while forced on
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_r <= 16'h0000;
         tick <= 1'b0;
      end
      else if (!run)
      begin
         cnt_r <= 16'h0000;
         tick <= 1'b0;
      end
      else if (cnt_r == LAST)
      begin
         cnt_r <= 16'h0000;
         tick <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + 16'h0001;
         tick <= 1'b0;
      end
   end
endmodule

// File: tb/wdt_top_assertions.sv
// checker: bus handshake and output relations of the watchdog
`timescale 1ns/1ps
module wdt_top_checker #(
   parameter int CLK_HZ = 40000000,
   parameter int OSC_HZ = 32000
)
(
   // apb side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // core side
   input wire logic wake_req,
   input wire logic device_reset_req,
   input wire logic osc_on,
   input wire logic irq
);
   logic hard_r; // last config write set hard enable
   logic mask0_r; // last mask write was all zero
   wire wr_done = psel && penable && pready && pwrite;
   // follow config and mask writes
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         hard_r <= 1'b0;
         mask0_r <= 1'b0;
      end
      else if (wr_done && paddr == wdt_pkg::CONFIG_OFS)
         hard_r <= pwdata[wdt_pkg::CFG_HARDEN_BIT];
      else if (wr_done && paddr == wdt_pkg::MASK_OFS)
         mask0_r <= (pwdata[2:0] == 3'h0);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   error_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   unmapped_error_a: assert property (psel && !penable && paddr > wdt_pkg::COUNT_OFS |=> pslverr)
      else $error("unmapped access not refused");
   reset_pulse_a: assert property (device_reset_req |=> !device_reset_req)
      else $error("reset request longer than a cycle");
   wake_pulse_a: assert property (wake_req |=> !wake_req)
      else $error("wake request longer than a cycle");
   wake_not_reset_a: assert property (!(wake_req && device_reset_req))
      else $error("wake and reset together");
   event_needs_osc_a: assert property (wake_req || device_reset_req |-> $past(osc_on))
      else $error("event with oscillator off");
   hard_keeps_on_a: assert property (hard_r && $past(hard_r, 3) |-> osc_on)
      else $error("hard enabled watchdog stopped");
   masked_irq_low_a: assert property (mask0_r && $past(mask0_r, 2) |-> !irq)
      else $error("interrupt while all masked");
endmodule
bind wdt_top wdt_top_checker #(.CLK_HZ(CLK_HZ), .OSC_HZ(OSC_HZ)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .wake_req(wake_req), .device_reset_req(device_reset_req),
   .osc_on(osc_on), .irq(irq));

// File: tb/wdt_core_model.sv
// core model: counts wake requests and reset requests
`timescale 1ns/1ps
module wdt_core_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // requests from the watchdog
   input wire logic wake_req,
   input wire logic device_reset_req,
   // what the core saw
   output logic [7:0] wakes,
   output logic [7:0] resets
);
   // each wake request and each reset request adds one to its own count
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         wakes <= 8'h00;
         resets <= 8'h00;
      end
      else
      begin
         wakes <= wakes + {7'h00, wake_req};
         resets <= resets + {7'h00, device_reset_req};
      end
endmodule

// File: tb/tb_windowed_watchdog_timer.sv
// testbench: register level tests of the windowed watchdog
`timescale 1ns/1ps
module tb_windowed_watchdog_timer;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, wake_req, device_reset_req, osc_on, irq, err;
   logic [7:0] wakes, resets, w0, r0;
   logic [31:0] rd, cfg;
   int fails = 0;
   int checked = 0;
   int n, ex;
   always #12.5 pclk = ~pclk;
   // oscillator tick every 4 bus clocks
   wdt_top #(.CLK_HZ(40000000), .OSC_HZ(10000000)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wake_req(wake_req), .device_reset_req(device_reset_req), .osc_on(osc_on), .irq(irq));
   wdt_core_model u_core (.pclk(pclk), .presetn(presetn), .wake_req(wake_req),
      .device_reset_req(device_reset_req), .wakes(wakes), .resets(resets));
   // one apb transfer, setup then access until ready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (!pready && k < 50);
      // a slave that never answers counts against the run
      if (!pready)
         fails++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_flag(input logic got, input logic exp);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // wait for a wake or a reset request, counting cycles
   task automatic wait_evt();
      w0 = wakes;
      r0 = resets;
      n = 0;
      while (wakes == w0 && resets == r0 && n < 3000)
      begin
         @(posedge pclk);
         n++;
      end
      // no event at all counts against the run
      if (n >= 3000)
         fails++;
   endtask
   task automatic print_verdict;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ****************************************************************
   // test sequence
   // ****************************************************************
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, wdt_pkg::CONFIG_OFS, 32'h0);
      check_word(rd, {22'h000000, wdt_pkg::CFG_RESET});
      apb(1'b0, 8'h20, 32'h0);
      check_flag(err, 1'b1);
      apb(1'b1, wdt_pkg::MASK_OFS, 32'h0);
      // timeout period for /32 at 1:1 and 1:2 and for /128 at 1:1, window off
      for (int i = 0; i < 3; i++)
      begin
         cfg = (i == 2) ? 32'h50 : 32'h40 | i;
         apb(1'b1, wdt_pkg::CONFIG_OFS, cfg);
         apb(1'b1, wdt_pkg::RESET_CTRL_OFS, 32'h20);
         wait_evt();
         ex = 4 * ((cfg[4] ? 128 : 32) << cfg[3:0]);
         check_flag(osc_on, 1'b1);
         check_flag(n > ex - 12 && n < ex + 12 && resets != r0, 1'b1);
         apb(1'b0, wdt_pkg::RESET_CTRL_OFS, 32'h0);
         check_word(rd & 32'h30, 32'h30);
         apb(1'b1, wdt_pkg::RESET_CTRL_OFS, 32'h0);
      end
      apb(1'b1, wdt_pkg::MASK_OFS, 32'h1);
      repeat (2) @(posedge pclk);
      check_flag(irq, 1'b1);
      apb(1'b0, wdt_pkg::STATUS_OFS, 32'h0);
      check_word(rd & 32'h1, 32'h1);
      // the interrupt line follows the cleared status one cycle later
      @(posedge pclk);
      check_flag(irq, 1'b0);
      // periodic clears and clock switches hold the timeout off
      apb(1'b1, wdt_pkg::CONFIG_OFS, 32'h41);
      apb(1'b1, wdt_pkg::RESET_CTRL_OFS, 32'h20);
      r0 = resets;
      for (int k = 0; k < 6; k++)
      begin
         repeat (150) @(posedge pclk);
         apb(1'b1, wdt_pkg::CMD_OFS, (k % 2) ? 32'h10 : 32'h01);
      end
      check_word({24'h0, resets}, {24'h0, r0});
      // sleep then idle: timeout wakes instead of resetting
      apb(1'b1, wdt_pkg::CONFIG_OFS, 32'h40);
      for (int b = 1; b < 3; b++)
      begin
         apb(1'b1, wdt_pkg::CMD_OFS, 32'h1 << b);
         wait_evt();
         check_word({wakes, resets}, {w0 + 8'h01, r0});
         apb(1'b0, wdt_pkg::RESET_CTRL_OFS, 32'h0);
         check_word(rd & 32'h10, 32'h10);
         apb(1'b1, wdt_pkg::RESET_CTRL_OFS, 32'h20);
      end
      // an outside wake before the time-out restarts the count
      apb(1'b1, wdt_pkg::CMD_OFS, 32'h2);
      repeat (100) @(posedge pclk);
      apb(1'b1, wdt_pkg::CMD_OFS, 32'h8);
      w0 = wakes;
      r0 = resets;
      repeat (60) @(posedge pclk);
      check_word({wakes, resets}, {w0, r0});
      // early clear in window mode is a fault, 1:8 so the window is not empty
      apb(1'b1, wdt_pkg::CONFIG_OFS, 32'h3);
      apb(1'b1, wdt_pkg::CMD_OFS, 32'h1);
      wait_evt();
      check_flag(n < 20 && resets != r0, 1'b1);
      apb(1'b0, wdt_pkg::STATUS_OFS, 32'h0);
      check_word(rd & 32'h2, 32'h2);
      // a clear inside the window is taken and holds the time-out off
      r0 = resets;
      repeat (850) @(posedge pclk);
      apb(1'b1, wdt_pkg::CMD_OFS, 32'h1);
      repeat (300) @(posedge pclk);
      check_word({24'h0, resets}, {24'h0, r0});
      // hard enable ignores the soft enable bit; disabling first clears the counts
      apb(1'b1, wdt_pkg::RESET_CTRL_OFS, 32'h0);
      apb(1'b1, wdt_pkg::CONFIG_OFS, 32'h240);
      wait_evt();
      check_flag(resets != r0, 1'b1);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, wdt_pkg::RESET_CTRL_OFS, 32'h0);
      check_word(rd, 32'h0);
      check_flag(osc_on, 1'b0);
      apb(1'b0, wdt_pkg::COUNT_OFS, 32'h0);
      check_word(rd, 32'h0);
      print_verdict;
   end
   // cut a hang short
   initial
   begin
      #500000;
      fails++;
      print_verdict;
   end
endmodule
